/* design/fdc_defines.svh */
// Offsets, field positions, reset values and encodings of the drive controller
`ifndef FDC_DEFINES_SVH
`define FDC_DEFINES_SVH

`define FDC_RAM_DEPTH        1024
`define FDC_OFS_COMMAND      10'h000
`define FDC_OFS_FUNCTION     10'h001
`define FDC_OFS_DRIVE        10'h002
`define FDC_OFS_SIDE         10'h003
`define FDC_OFS_SECTOR       10'h004
`define FDC_OFS_TRACK        10'h005
`define FDC_OFS_SPEED        10'h006
`define FDC_OFS_CONFIRM      10'h007
`define FDC_OFS_STATUS       10'h008
`define FDC_OFS_MEDIA        10'h009
`define FDC_OFS_RETRY        10'h02c
`define FDC_OFS_DSLIP1       10'h05b
`define FDC_OFS_DSLIP2       10'h05c
`define FDC_OFS_DCHK         10'h05d
`define FDC_OFS_ASLIP1       10'h05e
`define FDC_OFS_ASLIP2       10'h05f
`define FDC_OFS_WRONG_SEC    10'h060
`define FDC_OFS_WRONG_TRK    10'h061
`define FDC_OFS_ACHK         10'h062
`define FDC_OFS_USR_A        10'h07e
`define FDC_OFS_USR_B        10'h07f
`define FDC_OFS_USR_C        10'h080
`define FDC_OFS_BAD_TOTAL    10'h100
`define FDC_OFS_ERR_TRACK    10'h101
`define FDC_OFS_ERR_SIDE     10'h102
`define FDC_OFS_BAD_MAP      10'h103

`define FDC_SP_RAM_TOP       13'h0400
`define FDC_SP_PAGE_STEP     9'h140
`define FDC_SP_PAGE_GEN      9'h141
`define FDC_SP_PAGE_SHIFT    9'h142
`define FDC_SP_PAGE_STAT     9'h143

`define FDC_STEP_WREQ        0
`define FDC_STEP_HEAD        1
`define FDC_STEP_PH0         2
`define FDC_STEP_MODE_LO     6
`define FDC_STEP_MODE_HI     7
`define FDC_GEN_IRQ          0
`define FDC_GEN_DIAG         1
`define FDC_GEN_LOCK         2
`define FDC_GEN_MT0          3
`define FDC_GEN_MT1          4
`define FDC_GEN_DR0          5
`define FDC_GEN_DR1          6

`define FDC_STEP_RST         8'h01
`define FDC_GEN_RST          8'h78
`define FDC_IRQ_N_RST        1'b1

`define FDC_TAP_PRE          3'h3
`define FDC_BITS_PER_BYTE    4'h8

`define FDC_DRIVE_TOP        8'h00
`define FDC_DRIVE_BOTTOM     8'h80
`define FDC_TRACK_MAX        8'h2d
`define FDC_SPEED_FAST       8'hda
`define FDC_SPEED_SLOW       8'h23
`define FDC_STATUS_MAX       8'h1c

`define FDC_Z0_TRK           8'h03
`define FDC_Z1_TRK           8'h0a
`define FDC_Z2_TRK           8'h10
`define FDC_Z3_TRK           8'h16
`define FDC_Z4_TRK           8'h1c
`define FDC_Z5_TRK           8'h22
`define FDC_Z6_TRK           8'h29
`define FDC_Z0_SEC           8'h15
`define FDC_Z1_SEC           8'h14
`define FDC_Z2_SEC           8'h13
`define FDC_Z3_SEC           8'h12
`define FDC_Z4_SEC           8'h11
`define FDC_Z5_SEC           8'h10
`define FDC_Z6_SEC           8'h0f
`define FDC_Z7_SEC           8'h0e

`endif

/* design/fdc_drive_ctrl.sv */
// Drive interface, control latches, shared command RAM and host port of the disk controller
//
// Functional notes
// - Clear low empties shifter; clear high with select 00 holds the byte.
// - Select 01 shifts left, taking one read bit per tick.
// - Select 10 shifts right, presenting bits as write data.
// - Select 11 loads the byte written by the slave processor.
// - Shifter MSB set means the received byte is assembled.
// - Two latch outputs pick the operation; sequencer advances only on counter tap.
// - Serial read data from selected drive and head feeds the shifter.
// - Serial write data output carries shifter bits to the drive.
// - Sense input reports the item chosen by head select and phase zero.
// - Stepper latch is 8-bit addressable through low address lines.
// - Stepper latch drives active-low write request.
// - Stepper latch drives head select.
// - Stepper latch drives four carriage phase lines.
// - General latch is 8-bit addressable through low four address lines.
// - Interrupt bit drives inverted host interrupt and a pollable level.
// - Diagnostic bit polled by host; low means busy.
// - Lockout bit lets the slave processor shut out host accesses.
// - No new host acknowledge starts while lockout is high; one already given holds until the request drops.
// - General latch drives two motor and two drive select lines, active low.
// - Slave processor runs commands, leaves status in the control block.
// - Handshake command is acknowledged by zeroing the command byte.
// - After a read command the host waits for the disk interrupt.
// - Drive, track and speed parameters use fixed encodings.
// - Status code 00 to 1C, zero counters mean no error.
// - Highest valid sector falls by track zone.
`timescale 1ns/100ps

`include "fdc_defines.svh"

module fdc_drive_ctrl (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [12:0] sp_addr,
    input  wire logic [7:0]  sp_wdata,
    input  wire logic        sp_wr,
    input  wire logic        sp_rd,
    output logic      [7:0]  sp_rdata,
    input  wire logic        host_req,
    input  wire logic        host_wr,
    input  wire logic [9:0]  host_addr,
    input  wire logic [7:0]  host_wdata,
    output logic             host_ack,
    output logic      [7:0]  host_rdata,
    input  wire logic        serial_read_in,
    input  wire logic        drive_sense_in,
    output logic             serial_write_out,
    output logic             write_request_n,
    output logic             head_select,
    output logic      [3:0]  stepper_phase,
    output logic             disk_irq,
    output logic             host_io_irq_n,
    output logic             diag_busy_n,
    output logic             host_lockout,
    output logic             spindle_motor0_n,
    output logic             spindle_motor1_n,
    output logic             drive_select0_n,
    output logic             drive_select1_n
);

    fdc_pkg::fdc_host_bus_t   host_meta;
    fdc_pkg::fdc_host_bus_t   host_s;
    fdc_pkg::fdc_host_state_t hstate;
    fdc_pkg::fdc_shift_ctl_t  ctl;
    fdc_pkg::fdc_shift_op_t   mode;
    logic [1:0]               pin_meta;
    logic                     read_s;
    logic                     sense_s;
    logic [3:0]               tmr;
    logic                     tick;
    logic [7:0]               step_latch;
    logic [7:0]               gen_latch;
    logic [7:0]               next_gen;
    logic [7:0]               sreg;
    logic [7:0]               load_byte;
    logic                     load_pend;
    logic                     rd_taken;
    logic [3:0]               bits_left;
    logic [7:0]               mem [0:`FDC_RAM_DEPTH-1];
    logic [8:0]               sp_page;
    logic                     sp_acc;
    logic                     sp_ram;
    logic                     host_go;
    logic [7:0]               drive_sh;
    logic [7:0]               sector_sh;
    logic [7:0]               track_sh;
    logic [7:0]               speed_sh;
    logic                     param_bad;

    assign sp_page = sp_addr[12:4];
    assign sp_acc  = sp_wr | sp_rd;
    assign sp_ram  = sp_addr < `FDC_SP_RAM_TOP;

    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            host_meta <= '0;
            host_s    <= '0;
            pin_meta  <= 2'h0;
            read_s    <= 1'b0;
            sense_s   <= 1'b0;
        end else begin
            host_meta <= '{host_req, host_wr, host_addr, host_wdata};
            host_s    <= host_meta;
            pin_meta  <= {serial_read_in, drive_sense_in};
            read_s    <= pin_meta[1];
            sense_s   <= pin_meta[0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tmr  <= 4'h0;
            tick <= 1'b0;
        end else begin
            tmr  <= tmr + 4'h1;
            tick <= (tmr[2:0] == `FDC_TAP_PRE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step_latch <= `FDC_STEP_RST;
        end else if (sp_acc && sp_page == `FDC_SP_PAGE_STEP) begin
            step_latch[sp_addr[3:1]] <= sp_addr[0];
        end
    end

    assign write_request_n = step_latch[`FDC_STEP_WREQ];
    assign head_select     = step_latch[`FDC_STEP_HEAD];
    assign stepper_phase   = step_latch[`FDC_STEP_PH0 +: 4];

    always_comb begin
        next_gen = gen_latch;
        if (sp_acc && sp_page == `FDC_SP_PAGE_GEN) begin
            next_gen[sp_addr[3:1]] = sp_addr[0];
        end
    end

    // inverted interrupt kept as its own flop
    always_ff @(posedge clk) begin
        if (rst) begin
            gen_latch     <= `FDC_GEN_RST;
            host_io_irq_n <= `FDC_IRQ_N_RST;
        end else begin
            gen_latch     <= next_gen;
            host_io_irq_n <= ~next_gen[`FDC_GEN_IRQ];
        end
    end

    // interrupt level ends the host wait
    assign disk_irq         = gen_latch[`FDC_GEN_IRQ];
    assign diag_busy_n      = gen_latch[`FDC_GEN_DIAG];
    assign host_lockout     = gen_latch[`FDC_GEN_LOCK];
    assign spindle_motor0_n = gen_latch[`FDC_GEN_MT0];
    assign spindle_motor1_n = gen_latch[`FDC_GEN_MT1];
    assign drive_select0_n  = gen_latch[`FDC_GEN_DR0];
    assign drive_select1_n  = gen_latch[`FDC_GEN_DR1];

    function automatic fdc_pkg::fdc_shift_ctl_t seq_rom(input fdc_pkg::fdc_shift_op_t m,
                                                       input logic qa,
                                                       input logic pend,
                                                       input logic taken,
                                                       input logic [3:0] left);
        fdc_pkg::fdc_shift_ctl_t r;
        r = '{1'b1, fdc_pkg::FDC_OP_HOLD};
        case (m)
            fdc_pkg::FDC_OP_LEFT: begin
                if (taken) begin
                    r = '{1'b0, fdc_pkg::FDC_OP_HOLD};
                end else if (!qa) begin
                    r = '{1'b1, fdc_pkg::FDC_OP_LEFT};
                end
            end
            fdc_pkg::FDC_OP_RIGHT: begin
                if (left != 4'h0) begin
                    r = '{1'b1, fdc_pkg::FDC_OP_RIGHT};
                end else if (pend) begin
                    r = '{1'b1, fdc_pkg::FDC_OP_LOAD};
                end
            end
            fdc_pkg::FDC_OP_LOAD: begin
                if (pend) begin
                    r = '{1'b1, fdc_pkg::FDC_OP_LOAD};
                end
            end
            default: begin
                r = '{1'b1, fdc_pkg::FDC_OP_HOLD};
            end
        endcase
        return r;
    endfunction

    // mode taken from two stepper latch outputs
    assign mode = fdc_pkg::fdc_shift_op_t'({step_latch[`FDC_STEP_MODE_HI], step_latch[`FDC_STEP_MODE_LO]});
    assign ctl  = seq_rom(mode, sreg[7], load_pend, rd_taken, bits_left);

    // clear and hold, shift in, shift out, load
    always_ff @(posedge clk) begin
        if (rst) begin
            sreg <= 8'h00;
        end else if (tick) begin
            if (!ctl.clear_n) begin
                sreg <= 8'h00;
            end else begin
                case (ctl.op)
                    fdc_pkg::FDC_OP_LEFT:  sreg <= {sreg[6:0], read_s};
                    fdc_pkg::FDC_OP_RIGHT: sreg <= {1'b0, sreg[7:1]};
                    fdc_pkg::FDC_OP_LOAD:  sreg <= load_byte;
                    default:               sreg <= sreg;
                endcase
            end
        end
    end

    // write data is the shifter low bit
    assign serial_write_out = sreg[0];

    // Bits still to send after a load
    always_ff @(posedge clk) begin
        if (rst) begin
            bits_left <= 4'h0;
        end else if (tick && ctl.clear_n && ctl.op == fdc_pkg::FDC_OP_LOAD) begin
            bits_left <= `FDC_BITS_PER_BYTE;
        end else if (tick && ctl.clear_n && ctl.op == fdc_pkg::FDC_OP_RIGHT) begin
            bits_left <= bits_left - 4'h1;
        end
    end

    // byte parked for the next load, a new write wins over the load
    always_ff @(posedge clk) begin
        if (rst) begin
            load_pend <= 1'b0;
            load_byte <= 8'h00;
        end else if (sp_wr && sp_page == `FDC_SP_PAGE_SHIFT) begin
            load_pend <= 1'b1;
            load_byte <= sp_wdata;
        end else if (tick && ctl.clear_n && ctl.op == fdc_pkg::FDC_OP_LOAD) begin
            load_pend <= 1'b0;
        end
    end

    // assembled byte read arms the clear, a new read wins over the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_taken <= 1'b0;
        end else if (sp_rd && sp_page == `FDC_SP_PAGE_SHIFT && sreg[7]) begin
            rd_taken <= 1'b1;
        end else if (tick && !ctl.clear_n) begin
            rd_taken <= 1'b0;
        end
    end

    // host served only while lockout is low and the processor leaves the RAM
    assign host_go = hstate == fdc_pkg::FDC_HS_SERVE && host_s.req && !gen_latch[`FDC_GEN_LOCK]
                     && !(sp_acc && sp_ram);

    // shared control block; processor has priority
    always_ff @(posedge clk) begin
        if (sp_wr && sp_ram) begin
            mem[sp_addr[9:0]] <= sp_wdata;
        end else if (host_go && host_s.wr) begin
            mem[host_s.addr] <= host_s.wdata;
        end
    end

    // Host access sequence
    always_ff @(posedge clk) begin
        if (rst) begin
            hstate     <= fdc_pkg::FDC_HS_IDLE;
            host_ack   <= 1'b0;
            host_rdata <= 8'h00;
        end else begin
            case (hstate)
                fdc_pkg::FDC_HS_IDLE: begin
                    if (host_s.req && !gen_latch[`FDC_GEN_LOCK]) begin
                        hstate <= fdc_pkg::FDC_HS_SERVE;
                    end
                end
                fdc_pkg::FDC_HS_SERVE: begin
                    if (!host_s.req) begin
                        hstate <= fdc_pkg::FDC_HS_IDLE;
                    end else if (host_go) begin
                        host_rdata <= mem[host_s.addr];
                        host_ack   <= 1'b1;
                        hstate     <= fdc_pkg::FDC_HS_ACK;
                    end
                end
                fdc_pkg::FDC_HS_ACK: begin
                    if (!host_s.req) begin
                        host_ack <= 1'b0;
                        hstate   <= fdc_pkg::FDC_HS_IDLE;
                    end
                end
                default: begin
                    host_ack <= 1'b0;
                    hstate   <= fdc_pkg::FDC_HS_IDLE;
                end
            endcase
        end
    end

    // parameter copies taken from host writes
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_sh  <= 8'h00;
            sector_sh <= 8'h00;
            track_sh  <= 8'h00;
            speed_sh  <= 8'h00;
        end else if (host_go && host_s.wr) begin
            if (host_s.addr == `FDC_OFS_DRIVE) drive_sh <= host_s.wdata;
            if (host_s.addr == `FDC_OFS_SECTOR) sector_sh <= host_s.wdata;
            if (host_s.addr == `FDC_OFS_TRACK) track_sh <= host_s.wdata;
            if (host_s.addr == `FDC_OFS_SPEED) speed_sh <= host_s.wdata;
        end
    end

    // highest sector of a track zone
    function automatic logic [7:0] max_sector(input logic [7:0] trk);
        logic [7:0] s;
        s = `FDC_Z7_SEC;
        if (trk <= `FDC_Z0_TRK) s = `FDC_Z0_SEC;
        else if (trk <= `FDC_Z1_TRK) s = `FDC_Z1_SEC;
        else if (trk <= `FDC_Z2_TRK) s = `FDC_Z2_SEC;
        else if (trk <= `FDC_Z3_TRK) s = `FDC_Z3_SEC;
        else if (trk <= `FDC_Z4_TRK) s = `FDC_Z4_SEC;
        else if (trk <= `FDC_Z5_TRK) s = `FDC_Z5_SEC;
        else if (trk <= `FDC_Z6_TRK) s = `FDC_Z6_SEC;
        return s;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            param_bad <= 1'b0;
        end else begin
            param_bad <= (drive_sh != `FDC_DRIVE_TOP && drive_sh != `FDC_DRIVE_BOTTOM)
                         || track_sh > `FDC_TRACK_MAX
                         || sector_sh > max_sector(track_sh)
                         || (speed_sh > `FDC_SPEED_SLOW && speed_sh < `FDC_SPEED_FAST);
        end
    end

    // sense item and completion visible to the processor
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_rdata <= 8'h00;
        end else if (sp_rd && sp_ram) begin
            sp_rdata <= mem[sp_addr[9:0]];
        end else if (sp_rd) begin
            case (sp_page)
                `FDC_SP_PAGE_STEP:  sp_rdata <= step_latch;
                `FDC_SP_PAGE_GEN:   sp_rdata <= gen_latch;
                `FDC_SP_PAGE_SHIFT: sp_rdata <= sreg;
                `FDC_SP_PAGE_STAT:  sp_rdata <= {sreg[7], 3'h0, bits_left == 4'h0, load_pend, param_bad, sense_s};
                default:            sp_rdata <= 8'h00;
            endcase
        end
    end

    chk_clear_empties: assert property (@(posedge clk) disable iff (rst)
        tick && !ctl.clear_n |=> sreg == 8'h00) else $error("shifter not cleared");
    chk_hold_keeps: assert property (@(posedge clk) disable iff (rst)
        tick && ctl == '{1'b1, fdc_pkg::FDC_OP_HOLD} |=> $stable(sreg)) else $error("hold changed byte");
    chk_shift_in: assert property (@(posedge clk) disable iff (rst)
        tick && ctl == '{1'b1, fdc_pkg::FDC_OP_LEFT} |=> sreg == {$past(sreg[6:0]), $past(read_s)})
        else $error("left shift wrong");
    chk_shift_out: assert property (@(posedge clk) disable iff (rst)
        tick && ctl == '{1'b1, fdc_pkg::FDC_OP_RIGHT} |=> serial_write_out == $past(sreg[1]))
        else $error("write data wrong");
    chk_par_load: assert property (@(posedge clk) disable iff (rst)
        tick && ctl == '{1'b1, fdc_pkg::FDC_OP_LOAD} |=> sreg == $past(load_byte) && !load_pend)
        else $error("load wrong");
    chk_tap_only: assert property (@(posedge clk) disable iff (rst)
        tick |=> !tick [*7]) else $error("tap too frequent");
    chk_irq_invert: assert property (@(posedge clk) disable iff (rst)
        host_io_irq_n == !disk_irq) else $error("interrupt not inverted");
    chk_no_ack_locked: assert property (@(posedge clk) disable iff (rst)
        $rose(host_ack) |-> !$past(host_lockout)) else $error("ack while locked");
    chk_gen_write: assert property (@(posedge clk) disable iff (rst)
        sp_wr && sp_page == `FDC_SP_PAGE_GEN |=> gen_latch[$past(sp_addr[3:1])] == $past(sp_addr[0]))
        else $error("general latch bit not written");

endmodule

/* design/fdc_pkg.sv */
// Types shared by the drive controller
package fdc_pkg;

    typedef struct packed {
        logic       req;
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } fdc_host_bus_t;

    typedef enum logic [1:0] {
        FDC_OP_HOLD  = 2'b00,
        FDC_OP_LEFT  = 2'b01,
        FDC_OP_RIGHT = 2'b10,
        FDC_OP_LOAD  = 2'b11
    } fdc_shift_op_t;

    typedef struct packed {
        logic          clear_n;
        fdc_shift_op_t op;
    } fdc_shift_ctl_t;

    typedef enum logic [2:0] {
        FDC_HS_IDLE  = 3'b001,
        FDC_HS_SERVE = 3'b010,
        FDC_HS_ACK   = 3'b100
    } fdc_host_state_t;

endpackage

/* test/fdc_drive_model.sv */
// Behavioural single drive: serial read stream and sense line
`timescale 1ns/100ps
module fdc_drive_model #(
    parameter logic [3:0] SENSE_ITEMS = 4'h6
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic data_bit,
    input  wire logic head_select,
    input  wire logic phase0,
    input  wire logic drive_sel_n,
    output logic      serial_read_in,
    output logic      drive_sense_in
);
    // only the selected drive streams data
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_read_in <= 1'b0;
        end else begin
            serial_read_in <= drive_sel_n ? ~serial_read_in : data_bit;
        end
    end
    // item chosen by head select and phase zero
    assign drive_sense_in = SENSE_ITEMS[{head_select, phase0}];
endmodule

/* test/floppy_drive_interface_and_command_block_tb.sv */
// Self-checking bench for the drive controller
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module floppy_drive_interface_and_command_block_tb;
    localparam logic [3:0] SENSE = 4'h6;
    logic clk, rst, sp_wr, sp_rd, data_bit;
    logic [12:0] sp_addr;
    logic [7:0] sp_wdata, sp_rdata, host_rdata, st, gn, d, b;
    fdc_pkg::fdc_host_bus_t hb;
    logic host_ack, serial_read_in, drive_sense_in, serial_write_out, write_request_n, head_select;
    logic disk_irq, host_io_irq_n, diag_busy_n, host_lockout;
    logic spindle_motor0_n, spindle_motor1_n, drive_select0_n, drive_select1_n;
    logic [3:0] stepper_phase;
    logic [31:0] seed = 32'd86039;
    int fails = 0, checked = 0, cyc = 0;
    wire logic [13:0] outs = {stepper_phase, head_select, write_request_n, drive_select1_n, drive_select0_n,
        spindle_motor1_n, spindle_motor0_n, host_lockout, diag_busy_n, disk_irq, host_io_irq_n};
    fdc_drive_ctrl fdc_drive_ctrl_inst (.clk(clk), .rst(rst), .sp_addr(sp_addr), .sp_wdata(sp_wdata),
        .sp_wr(sp_wr), .sp_rd(sp_rd), .sp_rdata(sp_rdata), .host_req(hb.req), .host_wr(hb.wr),
        .host_addr(hb.addr), .host_wdata(hb.wdata), .host_ack(host_ack), .host_rdata(host_rdata),
        .serial_read_in(serial_read_in), .drive_sense_in(drive_sense_in), .serial_write_out(serial_write_out),
        .write_request_n(write_request_n), .head_select(head_select), .stepper_phase(stepper_phase),
        .disk_irq(disk_irq), .host_io_irq_n(host_io_irq_n), .diag_busy_n(diag_busy_n),
        .host_lockout(host_lockout), .spindle_motor0_n(spindle_motor0_n), .spindle_motor1_n(spindle_motor1_n),
        .drive_select0_n(drive_select0_n), .drive_select1_n(drive_select1_n));
    fdc_drive_model #(.SENSE_ITEMS(SENSE)) fdc_drive_model_inst (.clk(clk), .rst(rst), .data_bit(data_bit),
        .head_select(head_select), .phase0(stepper_phase[0]), .drive_sel_n(drive_select0_n),
        .serial_read_in(serial_read_in), .drive_sense_in(drive_sense_in));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [13:0] exp_out(input logic [7:0] s, input logic [7:0] g);
        return {s[5:0], g[6:0], ~g[0]};
    endfunction
    task automatic conclude();
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic sp(input logic [12:0] a, input logic w, input logic [7:0] v);
        sp_addr <= a;
        sp_wdata <= v;
        sp_wr <= w;
        sp_rd <= !w;
        @(posedge clk);
        sp_wr <= 1'b0;
        sp_rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [12:0] a, output logic [7:0] v);
        sp(a, 1'b0, 8'h00);
        v = sp_rdata;
    endtask
    task automatic lat(input logic g, input logic [2:0] i, input logic v);
        sp(13'h1400 | 13'({g, i, v}), 1'b1, 8'h00);
        if (g) gn[i] = v;
        else st[i] = v;
        `CHK(outs, exp_out(st, gn))
    endtask
    task automatic poll(input int k, input logic v);
        int n = 0;
        do begin
            rd(13'h1430, d);
            n++;
        end while (d[k] !== v && n < 100);
        `CHK(d[k], v)
    endtask
    task automatic host(input logic w, input logic [9:0] a, input logic [7:0] v, output logic [7:0] q);
        int n = 0;
        hb <= '{1'b1, w, a, v};
        do begin
            @(posedge clk);
            n++;
        end while (host_ack !== 1'b1 && n < 50);
        q = host_rdata;
        `CHK(host_ack, 1'b1)
        hb.req <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (host_ack !== 1'b0 && n < 100);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        rst = 1'b1;
        {sp_wr, sp_rd, data_bit, sp_addr, sp_wdata} = '0;
        hb = '0;
        st = 8'h01;
        gn = 8'h78;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({outs, serial_write_out, host_ack}, {exp_out(st, gn), 2'b00})
        for (int k = 0; k < 40; k++) lat(1'(rnd()), 3'(rnd()), 1'(rnd()));
        lat(1'b1, 3'h2, 1'b0);
        for (int k = 0; k < 4; k++) begin
            lat(1'b0, 3'h1, k[1]);
            lat(1'b0, 3'h2, k[0]);
            repeat (4) @(posedge clk);
            rd(13'h1430, d);
            `CHK(d[0], SENSE[k])
        end
        for (int k = 7; k > 1; k--) lat(1'b0, 3'(k), k == 7);
        lat(1'b0, 3'h6, 1'b1);
        b = 8'(rnd()) | 8'h80;
        sp(13'h1420, 1'b1, b);
        poll(2, 1'b0);
        // Leave load mode through shift left, which holds while the top bit is set
        lat(1'b0, 3'h7, 1'b0);
        lat(1'b0, 3'h6, 1'b0);
        repeat (24) @(posedge clk);
        rd(13'h1420, d);
        `CHK({d, serial_write_out}, {b, b[0]})
        lat(1'b0, 3'h7, 1'b1);
        poll(3, 1'b1);
        b = 8'(rnd());
        sp(13'h1420, 1'b1, b);
        poll(2, 1'b0);
        for (int k = 0; k < 8; k++) begin
            `CHK(serial_write_out, b[k])
            repeat (8) @(posedge clk);
        end
        lat(1'b0, 3'h7, 1'b0);
        lat(1'b0, 3'h6, 1'b1);
        lat(1'b1, 3'h5, 1'b0);
        data_bit <= 1'b1;
        poll(7, 1'b1);
        rd(13'h1420, d);
        data_bit <= 1'b0;
        repeat (80) @(posedge clk);
        rd(13'h1420, d);
        `CHK(d, 8'h00)
        data_bit <= 1'b1;
        poll(7, 1'b1);
        rd(13'h1420, d);
        `CHK(d, 8'hff)
        host(1'b1, 10'h000, 8'h80, d);
        rd(13'h0000, d);
        `CHK(d, 8'h80)
        sp(13'h0000, 1'b1, 8'h00);
        host(1'b0, 10'h000, 8'h00, d);
        `CHK(d, 8'h00)
        for (int k = 0; k < 6; k++) begin
            b = 8'(rnd());
            host(1'b1, 10'(k * 37), b, d);
            rd(13'(k * 37), d);
            `CHK(d, b)
            sp(13'(k * 37), 1'b1, ~b);
            host(1'b0, 10'(k * 37), 8'h00, d);
            `CHK(d, ~b)
        end
        host(1'b1, 10'h005, 8'h2a, d);
        host(1'b1, 10'h004, 8'h0f, d);
        rd(13'h1430, d);
        `CHK(d[1], 1'b1)
        host(1'b1, 10'h004, 8'h0e, d);
        host(1'b1, 10'h006, 8'h24, d);
        rd(13'h1430, d);
        `CHK(d[1], 1'b1)
        host(1'b1, 10'h006, 8'hda, d);
        rd(13'h1430, d);
        `CHK(d[1], 1'b0)
        b = 8'(rnd() % 101);
        host(1'b1, 10'h02c, b, d);
        rd(13'h002c, d);
        `CHK(d, b)
        lat(1'b1, 3'h2, 1'b1);
        hb <= '{1'b1, 1'b0, 10'h008, 8'h00};
        repeat (40) begin
            @(posedge clk);
            `CHK(host_ack, 1'b0)
        end
        lat(1'b1, 3'h2, 1'b0);
        host(1'b0, 10'h008, 8'h00, d);
        conclude();
    end
endmodule
